// ==== verilog/tvof_regs.vh ====
// Register offsets, fields, reset values and timing for the video output formatter
`ifndef TVOF_REGS_VH
`define TVOF_REGS_VH

`define TVOF_ADDR_CTRL      8'hcb
`define TVOF_ADDR_POL       8'hcc
`define TVOF_ADDR_TOFS_TL   8'he8
`define TVOF_ADDR_DLL_TRIM  8'he9
`define TVOF_ADDR_TOFS_TR   8'hea
`define TVOF_ADDR_TOFS_BL   8'hec
`define TVOF_ADDR_TOFS_BR   8'hee

`define TVOF_CTRL_RESET     8'h03
`define TVOF_POL_RESET      8'h41
`define TVOF_TOFS_RESET     8'h7f
`define TVOF_TRIM_RESET     8'h80

// Format field sits in control bits 5:4
`define TVOF_FMT_LSB        4
`define TVOF_FMT_MSB        5
`define TVOF_FMT_FULL       2'h0
`define TVOF_FMT_MSB8       2'h1
`define TVOF_FMT_SPLIT_LH   2'h2
`define TVOF_FMT_SPLIT_HL   2'h3

`define TVOF_POL_EDGE       0
`define TVOF_POL_LINE       1
`define TVOF_POL_FRAME      2
`define TVOF_POL_EXTRA_SYNC      3
`define TVOF_POL_SIGNED     4
`define TVOF_POL_RSVD       5
`define TVOF_POL_SATPIN     6
`define TVOF_POL_FORCE      7

`define TVOF_FULL_UNSIGNED  12'hfff
`define TVOF_FULL_SIGNED    12'h7ff
`define TVOF_SIGN_FLIP      12'h800

// Pixel clock half period in 5 ns system cycles
`define TVOF_CLK_NS         5
`define TVOF_HALF_NS        10
`define TVOF_HALF_CYCLES    (`TVOF_HALF_NS / `TVOF_CLK_NS)

`endif

// ==== verilog/tvof_clkgen.v ====
// Pixel clock divider with launch-edge strobe
`timescale 1ns/10ps
`include "tvof_regs.vh"
module tvof_clkgen
#(
    parameter HALF = `TVOF_HALF_CYCLES
)
(
    input  wire clk_in,
    input  wire resetn_in,
    input  wire edge_rise_in,
    output wire pclk_out,
    output wire launch_out
);

    reg  [7:0] cnt_reg;
    reg        pclk_reg;
    wire       toggle;

    assign toggle     = (cnt_reg == HALF[7:0] - 8'h01);
    // Launch where the clock moves to the selected level
    assign launch_out = toggle & ((~pclk_reg) == edge_rise_in);
    assign pclk_out   = pclk_reg;

    // Free-running divider, never stops between frames
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            cnt_reg  <= 8'h00;
            pclk_reg <= 1'b0;
        end
        else if (toggle)
        begin
            cnt_reg  <= 8'h00;
            pclk_reg <= ~pclk_reg;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // tvof_clkgen

// ==== verilog/tvof_pixcode.v ====
// Pixel value coding and beat layout
`timescale 1ns/10ps
module tvof_pixcode
(
    input  wire [11:0] raw_in,
    input  wire        sat_in,
    input  wire        signed_in,
    input  wire        force_in,
    input  wire [1:0]  fmt_in,
    input  wire        second_in,
    output reg  [11:0] data_out,
    output reg         low_beat_out
);
    `include "tvof_regs.vh"

    reg [11:0] val;

    // Low byte or high nibble placed on low lines
    function [11:0] tvof_byte;
        input [11:0] v;
        input        hi;
        begin
            tvof_byte = hi ? {8'h00, v[11:8]} : {4'h0, v[7:0]};
        end
    endfunction

    // Coding, forcing, then placement per format
    always @*
    begin
        val = signed_in ? (raw_in ^ `TVOF_SIGN_FLIP) : raw_in;
        if (force_in && sat_in)
            val = signed_in ? `TVOF_FULL_SIGNED : `TVOF_FULL_UNSIGNED;
        low_beat_out = 1'b1;
        case (fmt_in)
            `TVOF_FMT_FULL:
                data_out = val;
            `TVOF_FMT_MSB8:
                data_out = {4'h0, val[11:4]};
            `TVOF_FMT_SPLIT_LH:
            begin
                data_out     = tvof_byte(val, second_in);
                low_beat_out = ~second_in;
            end
            `TVOF_FMT_SPLIT_HL:
            begin
                data_out     = tvof_byte(val, ~second_in);
                low_beat_out = second_in;
            end
            default:
                data_out = val;
        endcase
    end
endmodule // tvof_pixcode

// ==== verilog/tvof_formatter.v ====
// Video port output formatter: registers, beat sequencing, pin drivers
`timescale 1ns/10ps
`include "tvof_regs.vh"
module tvof_formatter
#(
    parameter HALF = `TVOF_HALF_CYCLES
)
(
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        pix_valid_in,
    input  wire [11:0] pix_data_in,
    input  wire        pix_sat_in,
    input  wire        pix_line_in,
    input  wire        pix_frame_in,
    input  wire        pix_extra_sync_in,
    output reg         pix_ack_out,
    output wire        pixel_clock_out,
    output reg  [11:0] video_data_out,
    output reg         line_sync_out,
    output reg         frame_sync_out,
    output reg         extra_sync_sat_out
);

    localparam ST_NEXT   = 2'b01;
    localparam ST_SECOND = 2'b10;

    // Register file
    reg  [7:0]  ctrl_reg;
    reg  [7:0]  pol_reg;
    reg  [7:0]  tofs_tl_reg;
    reg  [7:0]  tofs_tr_reg;
    reg  [7:0]  tofs_bl_reg;
    reg  [7:0]  tofs_br_reg;
    reg  [7:0]  trim_reg;
    reg  [7:0]  rdata_next;

    // Beat state and latched pixel
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [11:0] pix_reg;
    reg         sat_reg;
    reg         line_reg;
    reg         frame_reg;
    reg         extra_sync_reg;
    reg         take;
    reg         second;

    wire        launch;
    wire        pclk;
    wire [1:0]  fmt;
    wire        split;
    wire [11:0] coded;
    wire        low_beat;
    wire [11:0] cur_pix;
    wire        cur_sat;
    wire        cur_line;
    wire        cur_frame;
    wire        cur_extra_sync;
    wire        shared_pin;

    assign fmt   = ctrl_reg[`TVOF_FMT_MSB:`TVOF_FMT_LSB];
    assign split = fmt[1];

    // Divider makes the pixel clock; launch pulses on chosen edge
    tvof_clkgen #(.HALF(HALF)) u_clkgen
    (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .edge_rise_in (pol_reg[`TVOF_POL_EDGE]),
        .pclk_out     (pclk),
        .launch_out   (launch)
    );
    assign pixel_clock_out = pclk;

    // Register writes; reserved polarity bit kept at zero
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            ctrl_reg    <= `TVOF_CTRL_RESET;
            pol_reg     <= `TVOF_POL_RESET;
            tofs_tl_reg <= `TVOF_TOFS_RESET;
            tofs_tr_reg <= `TVOF_TOFS_RESET;
            tofs_bl_reg <= `TVOF_TOFS_RESET;
            tofs_br_reg <= `TVOF_TOFS_RESET;
            trim_reg    <= `TVOF_TRIM_RESET;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `TVOF_ADDR_CTRL:     ctrl_reg    <= reg_wdata_in;
                `TVOF_ADDR_POL:      pol_reg     <= reg_wdata_in & ~(8'h01 << `TVOF_POL_RSVD);
                `TVOF_ADDR_TOFS_TL:  tofs_tl_reg <= reg_wdata_in;
                `TVOF_ADDR_DLL_TRIM: trim_reg    <= reg_wdata_in;
                `TVOF_ADDR_TOFS_TR:  tofs_tr_reg <= reg_wdata_in;
                `TVOF_ADDR_TOFS_BL:  tofs_bl_reg <= reg_wdata_in;
                `TVOF_ADDR_TOFS_BR:  tofs_br_reg <= reg_wdata_in;
                default:             ctrl_reg    <= ctrl_reg;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        case (reg_addr_in)
            `TVOF_ADDR_CTRL:     rdata_next = ctrl_reg;
            `TVOF_ADDR_POL:      rdata_next = pol_reg;
            `TVOF_ADDR_TOFS_TL:  rdata_next = tofs_tl_reg;
            `TVOF_ADDR_DLL_TRIM: rdata_next = trim_reg;
            `TVOF_ADDR_TOFS_TR:  rdata_next = tofs_tr_reg;
            `TVOF_ADDR_TOFS_BL:  rdata_next = tofs_bl_reg;
            `TVOF_ADDR_TOFS_BR:  rdata_next = tofs_br_reg;
            default:             rdata_next = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always @(posedge clk_in)
    begin
        if (!resetn_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
            reg_rdata_out <= rdata_next;
    end

    // Beat sequencing: a new pixel only when no second beat is owed
    always @*
    begin
        take       = 1'b0;
        second     = 1'b0;
        state_next = state_reg;
        case (state_reg)
            ST_NEXT:
            begin
                if (launch && pix_valid_in)
                begin
                    take = 1'b1;
                    if (split)
                        state_next = ST_SECOND;
                end
            end
            ST_SECOND:
            begin
                second = 1'b1;
                if (launch)
                    state_next = ST_NEXT;
            end
            default:
                state_next = ST_NEXT;
        endcase
    end

    // Current beat uses fresh input on a take, latched pixel otherwise; frame sync always uses the live input
    assign cur_pix   = take ? pix_data_in : pix_reg;
    assign cur_sat   = take ? pix_sat_in : sat_reg;
    assign cur_line  = take ? pix_line_in : line_reg;
    assign cur_frame = pix_frame_in;
    assign cur_extra_sync = take ? pix_extra_sync_in : extra_sync_reg;

    tvof_pixcode u_pixcode
    (
        .raw_in       (cur_pix),
        .sat_in       (cur_sat),
        .signed_in    (pol_reg[`TVOF_POL_SIGNED]),
        .force_in     (pol_reg[`TVOF_POL_FORCE]),
        .fmt_in       (fmt),
        .second_in    (second),
        .data_out     (coded),
        .low_beat_out (low_beat)
    );

    // Saturation travels only with the low byte in split modes
    assign shared_pin = pol_reg[`TVOF_POL_SATPIN]
                        ? (cur_sat & low_beat)
                        : (cur_extra_sync ^ ~pol_reg[`TVOF_POL_EXTRA_SYNC]);

    // State and pixel latch
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            state_reg <= ST_NEXT;
            pix_reg   <= 12'h000;
            sat_reg   <= 1'b0;
            line_reg  <= 1'b0;
            frame_reg <= 1'b0;
            extra_sync_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (take)
            begin
                pix_reg   <= pix_data_in;
                sat_reg   <= pix_sat_in;
                line_reg  <= pix_line_in;
                extra_sync_reg <= pix_extra_sync_in;
            end
            if (launch)
                frame_reg <= pix_frame_in;
        end
    end

    // Ack one cycle after a take, so the source can advance
    always @(posedge clk_in)
    begin
        if (!resetn_in)
            pix_ack_out <= 1'b0;
        else
            pix_ack_out <= take;
    end

    // Pins change only on launch, so they move with the chosen edge
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            video_data_out <= 12'h000;
            line_sync_out  <= 1'b1;
            frame_sync_out <= 1'b1;
            extra_sync_sat_out  <= 1'b0;
        end
        else if (launch)
        begin
            if (take || second)
            begin
                video_data_out <= coded;
                line_sync_out  <= cur_line ^ ~pol_reg[`TVOF_POL_LINE];
                extra_sync_sat_out  <= shared_pin;
            end
            else
            begin
                // Idle beat: data low, line sync inactive
                video_data_out <= 12'h000;
                line_sync_out  <= ~pol_reg[`TVOF_POL_LINE];
                extra_sync_sat_out  <= pol_reg[`TVOF_POL_SATPIN] ? 1'b0 : ~pol_reg[`TVOF_POL_EXTRA_SYNC];
            end
            frame_sync_out <= cur_frame ^ ~pol_reg[`TVOF_POL_FRAME];
        end
    end
endmodule // tvof_formatter

// ==== tb/tvof_formatter_checker.sv ====
// Port-level checks for the video output formatter
`timescale 1ns/10ps
module tvof_formatter_checker
#(
    parameter HALF = 2
)
(
    input wire        clk_in,
    input wire        resetn_in,
    input wire [7:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_rdata_out,
    input wire        pix_valid_in,
    input wire [11:0] pix_data_in,
    input wire        pix_sat_in,
    input wire        pix_line_in,
    input wire        pix_frame_in,
    input wire        pix_extra_sync_in,
    input wire        pix_ack_out,
    input wire        pixel_clock_out,
    input wire [11:0] video_data_out,
    input wire        line_sync_out,
    input wire        frame_sync_out,
    input wire        extra_sync_sat_out
);
    localparam int P = 2 * HALF;
    reg [7:0]  pol;
    reg [1:0]  fmt;
    reg [11:0] pv;
    reg [11:0] held;
    reg [7:0]  pold;
    reg        sv, xv, lv, fv;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // Shadow of the two format registers
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            pol <= 8'h41;
            fmt <= 2'h0;
        end
        else if (reg_wr_in && reg_addr_in == 8'hcc)
            pol <= reg_wdata_in;
        else if (reg_wr_in && reg_addr_in == 8'hcb)
            fmt <= reg_wdata_in[5:4];
    end
    // Inputs delayed one cycle so they line up with the ack cycle
    always @(posedge clk_in)
    begin
        pv <= pol[4] ? pix_data_in ^ 12'h800 : pix_data_in;
        if (pol[7] && pix_sat_in)
            pv <= pol[4] ? 12'h7ff : 12'hfff;
        {sv, xv, lv, fv} <= {pix_sat_in, pix_extra_sync_in, pix_line_in, pix_frame_in};
        // Settings the design used at the launch, not a write landing on it
        pold <= pol;
        if (pix_ack_out)
            held <= pv;
    end
    chk_data_launch: assert property ($changed(video_data_out)
        |-> $changed(pixel_clock_out) && pixel_clock_out == pold[0]) else $error("data moved off launch edge");
    chk_fmt_full: assert property (fmt == 2'h0 && pix_ack_out
        |-> video_data_out == pv) else $error("full beat wrong");
    chk_fmt_msb: assert property (fmt == 2'h1 && pix_ack_out
        |-> video_data_out == {4'h0, pv[11:4]}) else $error("msb beat wrong");
    chk_split_lh: assert property (fmt == 2'h2 && pix_ack_out |-> video_data_out == {4'h0, pv[7:0]}
        ##P video_data_out == {4'h0, held[11:8]}) else $error("low-high split wrong");
    chk_split_hl: assert property (fmt == 2'h3 && pix_ack_out |-> video_data_out == {4'h0, pv[11:8]}
        ##P video_data_out == {4'h0, held[7:0]}) else $error("high-low split wrong");
    chk_line_level: assert property (pix_ack_out |-> line_sync_out == !(lv ^ pold[1]))
        else $error("line sync level wrong");
    chk_line_hold: assert property (fmt[1] && pix_ack_out
        |-> ##P line_sync_out == $past(line_sync_out, P)) else $error("line sync dropped");
    chk_frame_level: assert property ($changed(pixel_clock_out) && pixel_clock_out == pold[0]
        |-> frame_sync_out == !(fv ^ pold[2])) else $error("frame sync level wrong");
    chk_shared_pin: assert property (!fmt[1] && pix_ack_out
        |-> extra_sync_sat_out == (pold[6] ? sv : !(xv ^ pold[3]))) else $error("shared pin wrong");
endmodule // tvof_formatter_checker

bind tvof_formatter tvof_formatter_checker #(.HALF(HALF)) u_chk
(
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pix_valid_in(pix_valid_in),
    .pix_data_in(pix_data_in), .pix_sat_in(pix_sat_in), .pix_line_in(pix_line_in), .pix_frame_in(pix_frame_in),
    .pix_extra_sync_in(pix_extra_sync_in), .pix_ack_out(pix_ack_out), .pixel_clock_out(pixel_clock_out),
    .video_data_out(video_data_out), .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
    .extra_sync_sat_out(extra_sync_sat_out)
);

// ==== tb/tvof_rx.sv ====
// Receiving end of the video port
`timescale 1ns/10ps
module tvof_rx
(
    input wire         rise_in,
    input wire         pclk_in,
    input wire [11:0]  data_in,
    input wire         line_in,
    input wire         pin_in,
    output reg [13:0]  cur_out,
    output reg [13:0]  prv_out,
    output int         cnt_out
);
    initial cnt_out = 0;
    // Sample mid-period, away from the launch edge
    always @(pclk_in)
    begin
        if (pclk_in !== rise_in)
        begin
            prv_out <= cur_out;
            cur_out <= {line_in, pin_in, data_in};
            cnt_out <= cnt_out + 1;
        end
    end
endmodule // tvof_rx

// ==== tb/tvof_formatter_test.sv ====
// Self-checking bench for the video output formatter
`timescale 1ns/10ps
`include "tvof_regs.vh"
module tvof_formatter_test;
    logic        clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, pix_valid_in = 1'b0;
    logic        pix_sat_in = 1'b0, pix_line_in = 1'b0, pix_frame_in = 1'b0, pix_extra_sync_in = 1'b0, edge_sel = 1'b1;
    logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    logic [11:0] pix_data_in = 12'h000;
    wire  [7:0]  reg_rdata_out;
    wire  [11:0] video_data_out;
    wire         pix_ack_out, pixel_clock_out, line_sync_out, frame_sync_out, extra_sync_sat_out;
    wire  [13:0] cur, prv;
    int          cnt, mismatches = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  pols [4] = '{8'h41, 8'hd1, 8'h1e, 8'h88};

    tvof_formatter #(.HALF(2)) dut
    (
        .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pix_valid_in(pix_valid_in),
        .pix_data_in(pix_data_in), .pix_sat_in(pix_sat_in), .pix_line_in(pix_line_in), .pix_frame_in(pix_frame_in),
        .pix_extra_sync_in(pix_extra_sync_in), .pix_ack_out(pix_ack_out), .pixel_clock_out(pixel_clock_out),
        .video_data_out(video_data_out), .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
        .extra_sync_sat_out(extra_sync_sat_out)
    );
    tvof_rx u_rx
    (
        .rise_in(edge_sel), .pclk_in(pixel_clock_out), .data_in(video_data_out), .line_in(line_sync_out),
        .pin_in(extra_sync_sat_out), .cur_out(cur), .prv_out(prv), .cnt_out(cnt)
    );

    // 200 MHz system clock
    always #2.5 clk_in = ~clk_in;

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        check("register", {6'h0, reg_rdata_out}, {6'h0, exp});
    endtask

    // Offer one pixel, hold it until the ack, note the capture count
    task automatic send_pixel(input logic [11:0] raw, input logic [3:0] fl, output int c0);
        int n;
        @(posedge clk_in);
        pix_valid_in <= 1'b1;
        pix_data_in <= raw;
        {pix_sat_in, pix_extra_sync_in, pix_line_in, pix_frame_in} <= fl;
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end while (pix_ack_out !== 1'b1 && n < 100);
        c0 = cnt;
        check("pixel ack", {13'h0000, pix_ack_out}, 14'h0001);
        @(posedge clk_in);
        pix_valid_in <= 1'b0;
        pix_line_in <= 1'b0;
    endtask

    // Expected {line, shared pin, data} of one beat
    function automatic logic [13:0] beat(input logic [1:0] f, input logic [7:0] p, input logic [11:0] raw,
                                         input logic [3:0] fl, input logic second);
        logic [11:0] v, d;
        logic        low;
        v = p[4] ? raw ^ 12'h800 : raw;
        if (p[7] && fl[3])
            v = p[4] ? 12'h7ff : 12'hfff;
        low = (f == 2'h2) ? !second : second;
        d = (f == 2'h0) ? v : (f == 2'h1) ? {4'h0, v[11:4]} : low ? {4'h0, v[7:0]} : {4'h0, v[11:8]};
        return {p[1], p[6] ? (fl[3] && (!f[1] || low)) : !(fl[2] ^ p[3]), d};
    endfunction

    initial
    begin
        int          c0;
        logic [7:0]  p;
        logic [11:0] raw;
        logic [3:0]  fl;
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        reg_read(8'hcc, 8'h41);
        reg_read(8'hcb, 8'h03);
        reg_read(8'he8, 8'h7f);
        reg_read(8'h10, 8'h00);
        reg_write(8'hcc, 8'hff);
        reg_read(8'hcc, 8'hdf);
        // Every format under four polarity settings
        for (int i = 0; i < 16; i++)
        begin
            p = pols[i / 4];
            fl = {i[0], !i[0], 1'b1, i[1]};
            raw = {i[3:0], 8'ha5} ^ 12'h5a3;
            reg_write(8'hcc, p);
            reg_write(8'hcb, {2'h0, i[1:0], 4'h3});
            edge_sel = p[0];
            repeat (8) @(posedge clk_in);
            send_pixel(raw, fl, c0);
            for (int k = 0; k < 40 && cnt < c0 + (i[1] ? 2 : 1); k++)
                @(negedge clk_in);
            check("beat count", 14'(cnt - c0), i[1] ? 14'h0002 : 14'h0001);
            if (i[1])
            begin
                check("first beat", prv, beat(i[1:0], p, raw, fl, 1'b0));
                check("second beat", cur, beat(i[1:0], p, raw, fl, 1'b1));
            end
            else
                check("single beat", cur, beat(i[1:0], p, raw, fl, 1'b0));
        end
        tally_and_finish();
    end
endmodule // tvof_formatter_test
